/* verification/ctrl_model.sv */
// Display controller model: select pins and serial master.
// Assumes the serial clock idles low and runs far below i_clk.
`timescale 1ns/1ps
module ctrl_model (
    input wire logic i_clk,
    input wire logic i_dout,
    output logic o_sel_n = 1'b1,
    output logic o_sclk = 1'b0,
    output logic o_din = 1'b0
);
    // drive and sample on falling edge
    task automatic xfer(input logic [23:0] f, output logic [15:0] r);
        r = 16'h0000;
        @(posedge i_clk) o_sel_n <= 1'b0;
        for (int i = 23; i >= 0; i--)
        begin
            @(posedge i_clk) o_din <= f[i];
            repeat (5) @(posedge i_clk);
            o_sclk <= 1'b1;
            repeat (5) @(posedge i_clk);
            if (i < 16) r[i] = i_dout;
            o_sclk <= 1'b0;
        end
        @(posedge i_clk) o_sel_n <= 1'b1;
        // Released line must not look like held data
        o_din <= ~o_din;
    endtask
endmodule

/* verification/rail_sequencer_sva.sv */
// Checker on the rail sequencer top ports.
// Assumes one clock and the active-low asynchronous reset.
`timescale 1ns/1ps
module rail_sequencer_chk (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [2:0] i_rail_fault,
    input wire logic i_serial_select_n,
    input wire logic o_serial_data_oe,
    input wire logic o_interrupt_out_n,
    input wire logic o_offset_rail_en,
    input wire logic o_bias_rail_en,
    input wire logic o_reset_rail_en,
    input wire logic o_fast_discharge,
    input wire logic o_led_enable,
    input wire logic o_led_switch_a,
    input wire logic o_led_switch_b,
    input wire logic o_led_switch_c
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // Fault while rails up, then all rails dropped together
    sequence fault_hit;
        (|i_rail_fault) && o_offset_rail_en;
    endsequence
    sequence discharged;
        o_fast_discharge && !o_offset_rail_en && !o_bias_rail_en && !o_reset_rail_en;
    endsequence
    led_gate_a: assert property (o_led_enable |-> o_offset_rail_en && o_bias_rail_en)
        else $error("led on before rails");
    fault_dis_a: assert property (fault_hit |-> ##2 discharged)
        else $error("no fast discharge");
    led_fault_a: assert property ((|i_rail_fault) |=> !o_led_enable)
        else $error("led kept on in fault");
    rail_pair_a: assert property (o_bias_rail_en == o_reset_rail_en)
        else $error("bias and reset differ");
    rail_order_a: assert property ($rose(o_bias_rail_en) |-> $past(o_offset_rail_en, 3))
        else $error("bias before offset");
    one_switch_a: assert property ($onehot0({o_led_switch_c, o_led_switch_b, o_led_switch_a}))
        else $error("two switches closed");
    oe_release_a: assert property (i_serial_select_n |=> !o_serial_data_oe)
        else $error("data out not released");
    irq_cause_a: assert property ($fell(o_interrupt_out_n) |-> $past(|i_rail_fault, 2))
        else $error("interrupt without fault");
endmodule

/* verification/rail_sequencer_test.sv */
// Bench for the rail sequencer with shortened sequence times.
// Assumes ctrl_model drives the select and serial pins.
`timescale 1ns/1ps
module dmd_rail_sequencer_and_color_strobe_test;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_projector_power_request = 1'b0;
    logic [1:0] i_colour_select = 2'h0;
    logic [2:0] i_rail_fault = 3'h0;
    logic i_serial_select_n, i_serial_clk, i_serial_data_in, o_serial_data_out;
    logic o_serial_data_oe, o_interrupt_out_n, o_mirror_init, o_offset_rail_en;
    logic o_bias_rail_en, o_reset_rail_en, o_fast_discharge, o_led_enable;
    logic o_led_switch_a, o_led_switch_b, o_led_switch_c;
    logic [9:0] o_led_current_code;
    logic [15:0] rd;
    int fails = 0;
    int checks = 0;
    int mdl[3];
    // Clock, 100 MHz
    always #5 i_clk = ~i_clk;
    ctrl_model P (.i_clk, .i_dout(o_serial_data_out), .o_sel_n(i_serial_select_n),
        .o_sclk(i_serial_clk), .o_din(i_serial_data_in));
    rail_sequencer #(.P_PROJ_DEGLITCH_US(3), .P_INIT_US(2), .P_OFS_DELAY_US(3),
        .P_BIAS_DELAY_US(5), .P_DOWN_DELAY_US(2)) DUT (.i_clk, .i_rst_n,
        .i_projector_power_request, .i_colour_select, .i_rail_fault, .i_serial_select_n,
        .i_serial_clk, .i_serial_data_in, .o_serial_data_out, .o_serial_data_oe,
        .o_interrupt_out_n, .o_mirror_init, .o_offset_rail_en, .o_bias_rail_en,
        .o_reset_rail_en, .o_fast_discharge, .o_led_enable, .o_led_switch_a,
        .o_led_switch_b, .o_led_switch_c, .o_led_current_code);
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        checks++;
        if (s !== e)
        begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic finish_test();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Bounded wait; running out ends the run
    task automatic wait_for(ref logic f, input logic v);
        int n;
        n = 0;
        while (f !== v && n < 5000)
        begin
            @(posedge i_clk);
            n++;
        end
        if (n == 5000)
        begin
            fails++;
            finish_test();
        end
    endtask
    initial
    begin
        void'($urandom(32'h2365F9CB));
        repeat (16) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(posedge i_clk);
        chk({o_interrupt_out_n, o_offset_rail_en, o_bias_rail_en}, 16'h4);
        P.xfer({1'b1, seq_pkg::REG_BREAK_MAKE_DELAY, 16'h0000}, rd);
        chk(rd, 16'h000A);
        P.xfer({1'b1, 7'h05, 16'h0000}, rd);
        chk(rd, 16'h0000);
        P.xfer({1'b0, seq_pkg::REG_BREAK_MAKE_DELAY, 16'h0001}, rd);
        for (int k = 0; k < 3; k++)
        begin
            mdl[k] = $urandom_range(1023, 1);
            P.xfer({1'b0, seq_pkg::REG_CURRENT_CODE_A + 7'(k), 16'(mdl[k])}, rd);
            P.xfer({1'b1, seq_pkg::REG_CURRENT_CODE_A + 7'(k), 16'h0000}, rd);
            chk(rd, 16'(mdl[k]));
        end
        $display("test registers done");
        i_projector_power_request <= 1'b1;
        wait_for(o_mirror_init, 1'b1);
        chk({o_mirror_init, o_offset_rail_en}, 16'h2);
        wait_for(o_offset_rail_en, 1'b1);
        chk({o_bias_rail_en, o_led_enable}, 16'h0);
        wait_for(o_bias_rail_en, 1'b1);
        repeat (3) @(posedge i_clk);
        chk(16'(o_led_enable), 16'h1);
        $display("test power up done");
        // Walk A, B, C then all open
        for (int s = 1; s < 5; s++)
        begin
            i_colour_select <= 2'(s);
            repeat (200) @(posedge i_clk);
            chk({o_led_switch_c, o_led_switch_b, o_led_switch_a}, 16'((1 << (s % 4)) >> 1));
            chk(o_led_current_code, (s % 4) != 0 ? 16'(mdl[s % 4 - 1]) : 16'h0);
        end
        $display("test strobe done");
        P.xfer({1'b0, seq_pkg::REG_INTERRUPT_MASK, 16'h0007}, rd);
        i_rail_fault <= 3'h2;
        repeat (4) @(posedge i_clk);
        chk({o_interrupt_out_n, o_fast_discharge, o_offset_rail_en, o_bias_rail_en}, 16'hC);
        P.xfer({1'b0, seq_pkg::REG_INTERRUPT_MASK, 16'h0000}, rd);
        repeat (4) @(posedge i_clk);
        chk(16'(o_interrupt_out_n), 16'h0);
        i_projector_power_request <= 1'b0;
        i_rail_fault <= 3'h0;
        wait_for(o_fast_discharge, 1'b0);
        chk({o_offset_rail_en, o_bias_rail_en}, 16'h0);
        $display("test fault done");
        finish_test();
    end
endmodule
bind rail_sequencer rail_sequencer_chk C (.i_clk, .i_rst_n, .i_rail_fault, .i_serial_select_n,
    .o_serial_data_oe, .o_interrupt_out_n, .o_offset_rail_en, .o_bias_rail_en,
    .o_reset_rail_en, .o_fast_discharge, .o_led_enable, .o_led_switch_a, .o_led_switch_b,
    .o_led_switch_c);

/* verilog/rail_sequencer.sv */
// Mirror-array rail sequencer with serial configuration port and colour strobe.
// Assumes all pins synchronous to i_clk and a serial clock well below i_clk/4.
//
// Operation
// - on request, init mirror array, offset rail under 10 ms, bias/reset 145 ms later.
// - LED driver and strobe decoder stay off until all three rails are on.
// - request low runs the normal rail power-down sequence.
// - any rail fault forces fast power-down, discharging all rails together.
// - masked rail fault keeps interrupt output high; shutdown timing unchanged.
// - select 0 opens all; 1, 2, 3 close switch A, B, C alone.
// - selected colour's own 10-bit current code drives the DAC; none when open.
// - on a colour change, open departing switches before closing new ones.
// - dead time between opening and closing is the delay register in 100 ns steps, plus one clock.
// - a switch closed before and after stays closed through the dead time.
// - configuration over serial port, including three 10-bit current codes.
// - serial data output released once chip select returns high.
// - serial data output changes after the falling serial clock edges of the last command bit and the first 15 data bits.
// - request pin deglitched; changes shorter than 1 ms ignored.
// - colour select deglitched; changes shorter than 300 ns ignored.
`timescale 1ns/1ps
module rail_sequencer #(
    parameter int P_PROJ_DEGLITCH_US = seq_pkg::PROJ_DEGLITCH_US,
    parameter int P_INIT_US = seq_pkg::INIT_US,
    parameter int P_OFS_DELAY_US = seq_pkg::OFS_DELAY_US,
    parameter int P_BIAS_DELAY_US = seq_pkg::BIAS_DELAY_US,
    parameter int P_DOWN_DELAY_US = seq_pkg::DOWN_DELAY_US
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_projector_power_request,
    input wire logic [1:0] i_colour_select,
    input wire logic [2:0] i_rail_fault,
    input wire logic i_serial_select_n,
    input wire logic i_serial_clk,
    input wire logic i_serial_data_in,
    output logic o_serial_data_out,
    output logic o_serial_data_oe,
    output logic o_interrupt_out_n,
    output logic o_mirror_init,
    output logic o_offset_rail_en,
    output logic o_bias_rail_en,
    output logic o_reset_rail_en,
    output logic o_fast_discharge,
    output logic o_led_enable,
    output logic o_led_switch_a,
    output logic o_led_switch_b,
    output logic o_led_switch_c,
    output logic [9:0] o_led_current_code
);
    localparam int US_W = seq_pkg::US_CNT_W;
    localparam int FRAME_W = seq_pkg::FRAME_BITS;

    // Refuse times that overflow the microsecond timer, or offset beyond 10 ms
    if (P_BIAS_DELAY_US >= (1 << US_W) || P_PROJ_DEGLITCH_US >= (1 << US_W)
        || P_INIT_US + P_OFS_DELAY_US >= 10000 || P_INIT_US < 1
        || P_OFS_DELAY_US < 1 || P_BIAS_DELAY_US < 1 || P_DOWN_DELAY_US < 1
        || P_PROJ_DEGLITCH_US < 1 || P_DOWN_DELAY_US >= (1 << US_W))
    begin : g_bad_param
        $error("rail_sequencer: timing parameter out of range");
    end

    typedef enum logic [2:0] {
        ST_OFF, ST_INIT, ST_WAIT_OFS, ST_WAIT_BIAS, ST_ON, ST_DOWN, ST_FAULT
    } seq_state_t;

    seq_state_t state;
    logic [seq_pkg::TICK_CNT_W-1:0] tick_cnt;
    logic us_tick;
    logic [US_W-1:0] timer;
    logic [US_W-1:0] proj_cnt;
    logic req;
    logic [7:0] break_make_delay;
    logic [7:0] interrupt_mask;
    logic [9:0] current_code_a;
    logic [9:0] current_code_b;
    logic [9:0] current_code_c;
    logic [2:0] fault_flags;
    logic sclk_q;
    logic [4:0] bit_cnt;
    logic [FRAME_W-1:0] rx_shift;
    logic [15:0] tx_shift;
    logic sclk_rise;
    logic sclk_fall;
    logic frame_done;
    logic [FRAME_W-1:0] frame;
    logic any_fault;

    strobe_if sb ();

    // one-microsecond enable from the system clock
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            tick_cnt <= '0;
            us_tick <= 1'b0;
        end
        else
        begin
            us_tick <= (tick_cnt == seq_pkg::TICK_CNT_W'(seq_pkg::TICK_CYCLES - 1));
            if (tick_cnt == seq_pkg::TICK_CNT_W'(seq_pkg::TICK_CYCLES - 1))
                tick_cnt <= '0;
            else
                tick_cnt <= tick_cnt + 1'b1;
        end
    end

    // request deglitch; a short pulse is forgotten when the pin returns
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            req <= 1'b0;
            proj_cnt <= '0;
        end
        else if (i_projector_power_request == req)
            proj_cnt <= '0;
        else if (us_tick)
        begin
            if (proj_cnt == US_W'(P_PROJ_DEGLITCH_US - 1))
            begin
                req <= i_projector_power_request;
                proj_cnt <= '0;
            end
            else
                proj_cnt <= proj_cnt + 1'b1;
        end
    end

    assign any_fault = |i_rail_fault;

    // Rail sequence; timer restarts on every state change except ST_INIT or ST_WAIT_OFS back to ST_OFF
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state <= ST_OFF;
            timer <= '0;
        end
        else
        begin
            if (us_tick)
                timer <= timer + 1'b1;
            if (any_fault && state != ST_OFF && state != ST_FAULT)
            begin
                state <= ST_FAULT;
                timer <= '0;
            end
            else
            begin
                unique case (state)
                    ST_OFF:
                    if (req)
                    begin
                        state <= ST_INIT;
                        timer <= '0;
                    end
                    ST_INIT:
                    if (!req)
                    begin
                        state <= ST_OFF;
                    end
                    else if (us_tick && timer == US_W'(P_INIT_US - 1))
                    begin
                        state <= ST_WAIT_OFS;
                        timer <= '0;
                    end
                    ST_WAIT_OFS:
                    if (!req)
                    begin
                        state <= ST_OFF;
                    end
                    else if (us_tick && timer == US_W'(P_OFS_DELAY_US - 1))
                    begin
                        state <= ST_WAIT_BIAS;
                        timer <= '0;
                    end
                    // bias and reset rails 145 ms later
                    ST_WAIT_BIAS:
                    if (!req)
                    begin
                        state <= ST_DOWN;
                        timer <= '0;
                    end
                    else if (us_tick && timer == US_W'(P_BIAS_DELAY_US - 1))
                    begin
                        state <= ST_ON;
                        timer <= '0;
                    end
                    ST_ON:
                    if (!req)
                    begin
                        state <= ST_DOWN;
                        timer <= '0;
                    end
                    // bias/reset off first, offset after delay
                    ST_DOWN:
                    if (us_tick && timer == US_W'(P_DOWN_DELAY_US - 1))
                    begin
                        state <= ST_OFF;
                        timer <= '0;
                    end
                    // Stay discharged until the request is withdrawn
                    ST_FAULT:
                    if (!req)
                    begin
                        state <= ST_OFF;
                        timer <= '0;
                    end
                    default:
                        state <= ST_OFF;
                endcase
            end
        end
    end

    // Rail outputs registered from the current state, one cycle behind the sequencer
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_mirror_init <= 1'b0;
            o_offset_rail_en <= 1'b0;
            o_bias_rail_en <= 1'b0;
            o_reset_rail_en <= 1'b0;
            o_fast_discharge <= 1'b0;
            o_led_enable <= 1'b0;
        end
        else
        begin
            o_mirror_init <= (state == ST_INIT);
            o_offset_rail_en <= (state == ST_WAIT_BIAS) || (state == ST_ON)
                || (state == ST_DOWN);
            o_bias_rail_en <= (state == ST_ON);
            o_reset_rail_en <= (state == ST_ON);
            o_fast_discharge <= (state == ST_FAULT);
            // LED driver only with all rails up
            o_led_enable <= (state == ST_ON) && !any_fault;
        end
    end

    // Serial edge detection; pins are synchronous so no extra stages
    assign sclk_rise = !i_serial_select_n && i_serial_clk && !sclk_q;
    assign sclk_fall = !i_serial_select_n && !i_serial_clk && sclk_q;
    assign frame_done = sclk_rise && bit_cnt == 5'(FRAME_W - 1);
    assign frame = {rx_shift[FRAME_W-2:0], i_serial_data_in};

    // Register read decode; unmapped offsets read as zero
    function automatic logic [15:0] read_reg(input logic [6:0] addr);
        read_reg = 16'h0000;
        unique case (addr)
            seq_pkg::REG_BREAK_MAKE_DELAY: read_reg = {8'h00, break_make_delay};
            seq_pkg::REG_INTERRUPT_MASK: read_reg = {8'h00, interrupt_mask};
            seq_pkg::REG_CURRENT_CODE_A: read_reg = {6'h00, current_code_a};
            seq_pkg::REG_CURRENT_CODE_B: read_reg = {6'h00, current_code_b};
            seq_pkg::REG_CURRENT_CODE_C: read_reg = {6'h00, current_code_c};
            seq_pkg::REG_STATUS:
            begin
                read_reg[seq_pkg::ST_FAULT_LSB +: 3] = fault_flags;
                read_reg[seq_pkg::ST_RAIL_LSB +: 3] =
                    {o_reset_rail_en, o_bias_rail_en, o_offset_rail_en};
                read_reg[seq_pkg::ST_LED_EN] = o_led_enable;
                read_reg[seq_pkg::ST_DISCHARGE] = o_fast_discharge;
            end
            default: read_reg = 16'h0000;
        endcase
    endfunction

    // controller changes data on falling edges, so sample on rising
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sclk_q <= 1'b0;
            bit_cnt <= 5'h00;
            rx_shift <= '0;
        end
        else
        begin
            sclk_q <= i_serial_clk;
            if (i_serial_select_n)
                bit_cnt <= 5'h00;
            else if (sclk_rise)
            begin
                rx_shift <= frame;
                bit_cnt <= frame_done ? 5'h00 : bit_cnt + 5'h01;
            end
        end
    end

    // output bit advances after each falling serial clock edge from the last command bit through the 15th data bit
    // driver released while chip select is high
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            tx_shift <= 16'h0000;
            o_serial_data_out <= 1'b0;
            o_serial_data_oe <= 1'b0;
        end
        else
        begin
            o_serial_data_oe <= !i_serial_select_n;
            if (sclk_rise && bit_cnt == 5'(seq_pkg::CMD_BITS - 1))
                tx_shift <= frame[seq_pkg::READ_BIT] ? read_reg(frame[6:0]) : 16'h0000;
            else if (sclk_fall && bit_cnt >= 5'(seq_pkg::CMD_BITS))
            begin
                o_serial_data_out <= tx_shift[15];
                tx_shift <= {tx_shift[14:0], 1'b0};
            end
        end
    end

    // register writes at the end of a write frame
    // delay register feeds the dead-time counter
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            break_make_delay <= seq_pkg::BBM_RST;
            interrupt_mask <= seq_pkg::MASK_RST;
            current_code_a <= seq_pkg::CODE_RST;
            current_code_b <= seq_pkg::CODE_RST;
            current_code_c <= seq_pkg::CODE_RST;
        end
        else if (frame_done && !frame[FRAME_W-1])
        begin
            unique case (frame[FRAME_W-2 -: seq_pkg::ADDR_W])
                seq_pkg::REG_BREAK_MAKE_DELAY: break_make_delay <= frame[7:0];
                seq_pkg::REG_INTERRUPT_MASK: interrupt_mask <= frame[7:0];
                seq_pkg::REG_CURRENT_CODE_A: current_code_a <= frame[9:0];
                seq_pkg::REG_CURRENT_CODE_B: current_code_b <= frame[9:0];
                seq_pkg::REG_CURRENT_CODE_C: current_code_c <= frame[9:0];
                default: ;
            endcase
        end
    end

    // Sticky fault flags, cleared by writing ones to status; a new fault wins
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            fault_flags <= 3'h0;
        else if (frame_done && !frame[FRAME_W-1]
            && frame[FRAME_W-2 -: seq_pkg::ADDR_W] == seq_pkg::REG_STATUS)
            fault_flags <= (fault_flags & ~frame[2:0]) | i_rail_fault;
        else
            fault_flags <= fault_flags | i_rail_fault;
    end

    // masked faults keep the interrupt high; sequencing ignores the mask
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_interrupt_out_n <= 1'b1;
        else
            o_interrupt_out_n <= !(|(fault_flags & ~interrupt_mask[2:0]));
    end

    // Strobe decoder connection
    assign sb.enable = o_led_enable;
    assign sb.colour_select = i_colour_select;
    assign sb.break_make_delay = break_make_delay;
    assign sb.current_code_a = current_code_a;
    assign sb.current_code_b = current_code_b;
    assign sb.current_code_c = current_code_c;

    strobe_decoder u_strobe (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .sb(sb.dec)
    );

    // Decoder outputs are flops already; mirrored here to keep ports registered
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_led_switch_a <= 1'b0;
            o_led_switch_b <= 1'b0;
            o_led_switch_c <= 1'b0;
            o_led_current_code <= 10'h000;
        end
        else
        begin
            o_led_switch_a <= sb.switches[0];
            o_led_switch_b <= sb.switches[1];
            o_led_switch_c <= sb.switches[2];
            o_led_current_code <= sb.dac_code;
        end
    end
endmodule

/* verilog/seq_pkg.sv */
// Shared constants for the mirror-rail sequencer and the colour strobe.
// Assumes a single 100 MHz system clock; all times are derived from it.
package seq_pkg;
    // Clock and time base
    localparam int CLK_MHZ = 100;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYCLES = TICK_NS * CLK_MHZ / 1000;
    localparam int TICK_CNT_W = $clog2(TICK_CYCLES);
    // Colour select deglitch, a least time, so rounded up
    localparam int SEL_DEGLITCH_NS = 300;
    localparam int SEL_DEGLITCH_CYCLES = (SEL_DEGLITCH_NS * CLK_MHZ + 999) / 1000;
    // One step of the break-before-make register
    localparam int BBM_STEP_NS = 100;
    localparam int BBM_STEP_CYCLES = (BBM_STEP_NS * CLK_MHZ + 999) / 1000;
    localparam int DEAD_CNT_W = 12;
    // Default sequence times in microseconds (top-level parameters)
    localparam int PROJ_DEGLITCH_US = 1000;
    localparam int INIT_US = 1000;
    localparam int OFS_DELAY_US = 5000;
    localparam int BIAS_DELAY_US = 145000;
    localparam int DOWN_DELAY_US = 1000;
    localparam int US_CNT_W = 18;
    // Serial frame: command byte then 16 data bits, MSB first
    localparam int CMD_BITS = 8;
    localparam int DATA_BITS = 16;
    localparam int FRAME_BITS = CMD_BITS + DATA_BITS;
    localparam int READ_BIT = 7;
    localparam int ADDR_W = 7;
    // Register offsets
    localparam logic [6:0] REG_BREAK_MAKE_DELAY = 7'h0B;
    localparam logic [6:0] REG_INTERRUPT_MASK = 7'h0D;
    localparam logic [6:0] REG_STATUS = 7'h0E;
    localparam logic [6:0] REG_CURRENT_CODE_A = 7'h10;
    localparam logic [6:0] REG_CURRENT_CODE_B = 7'h11;
    localparam logic [6:0] REG_CURRENT_CODE_C = 7'h12;
    // Reset values
    localparam logic [7:0] BBM_RST = 8'h0A;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [9:0] CODE_RST = 10'h000;
    // Status field positions
    localparam int ST_FAULT_LSB = 0;
    localparam int ST_RAIL_LSB = 4;
    localparam int ST_LED_EN = 7;
    localparam int ST_DISCHARGE = 8;
    // Colour select codes, common-anode map
    localparam logic [1:0] SEL_OFF = 2'h0;
    localparam logic [1:0] SEL_A = 2'h1;
    localparam logic [1:0] SEL_B = 2'h2;
    localparam logic [1:0] SEL_C = 2'h3;
endpackage

/* verilog/strobe_decoder.sv */
// Colour strobe decoder: deglitch, switch decode, break-before-make.
// Assumes select pins are synchronous to i_clk; switch bits are {c,b,a}.
`timescale 1ns/1ps
module strobe_decoder (
    input wire logic i_clk,
    input wire logic i_rst_n,
    strobe_if.dec sb
);
    typedef enum logic [0:0] {ST_IDLE, ST_DEAD} dec_state_t;

    dec_state_t state;
    logic [1:0] sel_stable;
    logic [4:0] sel_cnt;
    logic [2:0] pending;
    logic [seq_pkg::DEAD_CNT_W-1:0] dead_cnt;
    logic [2:0] target;

    // Common-anode map: one switch per colour code
    function automatic logic [2:0] sw_decode(input logic [1:0] sel);
        unique case (sel)
            seq_pkg::SEL_OFF: sw_decode = 3'h0;
            seq_pkg::SEL_A: sw_decode = 3'h1;
            seq_pkg::SEL_B: sw_decode = 3'h2;
            seq_pkg::SEL_C: sw_decode = 3'h4;
        endcase
    endfunction

    // Current code of the closed switch, zero when all are open
    function automatic logic [9:0] code_for(input logic [2:0] sw);
        code_for = 10'h000;
        if (sw[0])
            code_for = sb.current_code_a;
        else if (sw[1])
            code_for = sb.current_code_b;
        else if (sw[2])
            code_for = sb.current_code_c;
    endfunction

    // decoder held off until the rails are up
    assign target = sb.enable ? sw_decode(sel_stable) : 3'h0;

    // select deglitch; a change must hold this long to count
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sel_stable <= 2'h0;
            sel_cnt <= 5'h00;
        end
        else if (sb.colour_select == sel_stable)
            sel_cnt <= 5'h00;
        else if (sel_cnt == 5'(seq_pkg::SEL_DEGLITCH_CYCLES - 1))
        begin
            sel_stable <= sb.colour_select;
            sel_cnt <= 5'h00;
        end
        else
            sel_cnt <= sel_cnt + 5'h01;
    end

    // Switch sequencing; a change of select during dead time is taken afterwards
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state <= ST_IDLE;
            sb.switches <= 3'h0;
            sb.dac_code <= 10'h000;
            pending <= 3'h0;
            dead_cnt <= '0;
        end
        else if (!sb.enable)
        begin
            state <= ST_IDLE;
            sb.switches <= 3'h0;
            sb.dac_code <= 10'h000;
        end
        else
        begin
            unique case (state)
                ST_IDLE:
                begin
                    if ((target & ~sb.switches) == 3'h0)
                    begin
                        // Only opening: no dead time needed
                        sb.switches <= target;
                        sb.dac_code <= code_for(target);
                    end
                    else
                    begin
                        sb.switches <= sb.switches & target;
                        pending <= target;
                        dead_cnt <= seq_pkg::DEAD_CNT_W'(sb.break_make_delay)
                            * seq_pkg::DEAD_CNT_W'(seq_pkg::BBM_STEP_CYCLES);
                        state <= ST_DEAD;
                    end
                end
                ST_DEAD:
                begin
                    if (dead_cnt == '0)
                    begin
                        sb.switches <= pending;
                        sb.dac_code <= code_for(pending);
                        state <= ST_IDLE;
                    end
                    else
                        dead_cnt <= dead_cnt - 1'b1;
                end
            endcase
        end
    end
endmodule

/* verilog/strobe_if.sv */
// Carrier between the sequencer top and the colour strobe decoder.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface strobe_if;
    logic enable;
    logic [1:0] colour_select;
    logic [7:0] break_make_delay;
    logic [9:0] current_code_a;
    logic [9:0] current_code_b;
    logic [9:0] current_code_c;
    logic [2:0] switches;
    logic [9:0] dac_code;

    modport ctrl (
        output enable, colour_select, break_make_delay,
        output current_code_a, current_code_b, current_code_c,
        input switches, dac_code
    );
    modport dec (
        input enable, colour_select, break_make_delay,
        input current_code_a, current_code_b, current_code_c,
        output switches, dac_code
    );
endinterface
